// ### hdl/dcc_pkg.sv
// Package for the dual comparator control block.
// Holds register addresses, field positions, reset values and mode codes.
package dcc_pkg;
	localparam logic [7:0] ADDR_CMP1_CONTROL = 8'h9a;
	localparam logic [7:0] ADDR_CMP0_CONTROL = 8'h9b;
	localparam logic [7:0] ADDR_CMP1_MODE = 8'h9c;
	localparam logic [7:0] ADDR_CMP0_MODE = 8'h9d;
	localparam logic [7:0] ADDR_CMP1_INPUT_SELECT = 8'h9e;
	localparam logic [7:0] ADDR_CMP0_INPUT_SELECT = 8'h9f;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h02;
	localparam logic [7:0] RST_INPUT_SELECT = 8'hff;
	localparam logic [1:0] MUX_UNUSED_READ = 2'h3;
	localparam logic [1:0] MODE_UNUSED_READ = 2'h0;
	localparam int BIT_ON = 7;
	localparam int BIT_OUT = 6;
	localparam int BIT_RISE = 5;
	localparam int BIT_FALL = 4;
	localparam int POS_HYS_LO = 2;
	localparam int NEG_HYS_LO = 0;
	localparam int NEG_SEL_LO = 4;
	localparam int POS_SEL_LO = 0;
	localparam int MODE_LO = 0;
	localparam int SYNC_STAGES = 2;
	typedef enum logic [1:0] {
		DCC_RESP_100NS,
		DCC_RESP_175NS,
		DCC_RESP_320NS,
		DCC_RESP_1050NS
	} dcc_resp_e;
endpackage : dcc_pkg

// ### hdl/dcc_channel.sv
// One comparator channel: output synchroniser, edge detector and sticky flags.
// Assumes the raw output is asynchronous to i_sys_clk.
`timescale 1ns/1ps
module dcc_channel
(
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Analog output and flag clears.
	input wire logic i_cmp_raw,
	input wire logic i_clr_rise,
	input wire logic i_clr_fall,
	// State and flags.
	output logic o_state,
	output logic o_rise_flag,
	output logic o_fall_flag
);
	logic sync1_q;
	logic sync2_q;
	logic prev_q;
	logic rise_q;
	logic fall_q;

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
		end
		else
		begin
			sync1_q <= i_cmp_raw;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// Sticky edge flags, set wins over clear.
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end
		else
		begin
			rise_q <= (sync2_q & ~prev_q) | (rise_q & ~i_clr_rise);
			fall_q <= (~sync2_q & prev_q) | (fall_q & ~i_clr_fall);
		end
	end

	assign o_state = prev_q;
	assign o_rise_flag = rise_q;
	assign o_fall_flag = fall_q;
endmodule : dcc_channel

// ### hdl/dcc_top.sv
// Control and status registers for two voltage comparators.
// Assumes a byte wide special register port on i_sys_clk: single cycle write,
// combinational read data for the presented address.
`timescale 1ns/1ps
module dcc_top
(
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// Special register port.
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// Raw comparator outputs.
	input wire logic i_cmp0_raw,
	input wire logic i_cmp1_raw,
	// Comparator0 analog controls.
	output logic o_cmp0_on,
	output logic [1:0] o_cmp0_pos_hysteresis,
	output logic [1:0] o_cmp0_neg_hysteresis,
	output logic [1:0] o_cmp0_neg_input_select,
	output logic [1:0] o_cmp0_pos_input_select,
	output logic [1:0] o_cmp0_response_mode,
	// Comparator1 analog controls.
	output logic o_cmp1_on,
	output logic [1:0] o_cmp1_pos_hysteresis,
	output logic [1:0] o_cmp1_neg_hysteresis,
	output logic [1:0] o_cmp1_neg_input_select,
	output logic [1:0] o_cmp1_pos_input_select,
	output logic [1:0] o_cmp1_response_mode,
	// Interrupt requests.
	output logic o_cmp0_irq,
	output logic o_cmp1_irq
);
	logic rst_meta_q;
	logic rst_sync_q;
	logic [7:0] ctl_q [2];
	logic [7:0] mode_q [2];
	logic [7:0] sel_q [2];
	logic [1:0] state;
	logic [1:0] rise;
	logic [1:0] fall;
	logic [1:0] irq;
	logic [7:0] rdata_d;

	// Reset release through two flip-flops.
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	function automatic logic wr_hit(input logic [7:0] addr);
		wr_hit = i_reg_wr && (i_reg_addr == addr);
	endfunction : wr_hit

	function automatic logic clr_bit(input logic [7:0] addr, input int pos);
		clr_bit = wr_hit(addr) && !i_reg_wdata[pos];
	endfunction : clr_bit

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_chan
			localparam logic [7:0] A_CTL = (g == 0) ? dcc_pkg::ADDR_CMP0_CONTROL : dcc_pkg::ADDR_CMP1_CONTROL;
			localparam logic [7:0] A_MODE = (g == 0) ? dcc_pkg::ADDR_CMP0_MODE : dcc_pkg::ADDR_CMP1_MODE;
			localparam logic [7:0] A_SEL =
				(g == 0) ? dcc_pkg::ADDR_CMP0_INPUT_SELECT : dcc_pkg::ADDR_CMP1_INPUT_SELECT;

			always_ff @(posedge i_sys_clk or negedge rst_sync_q)
			begin
				if (!rst_sync_q)
					ctl_q[g] <= dcc_pkg::RST_CONTROL;
				else if (wr_hit(A_CTL))
					ctl_q[g] <= i_reg_wdata;
			end

			always_ff @(posedge i_sys_clk or negedge rst_sync_q)
			begin
				if (!rst_sync_q)
					mode_q[g] <= dcc_pkg::RST_MODE;
				else if (wr_hit(A_MODE))
					mode_q[g] <= {dcc_pkg::MODE_UNUSED_READ, i_reg_wdata[dcc_pkg::BIT_FALL +: 2],
						dcc_pkg::MODE_UNUSED_READ, i_reg_wdata[dcc_pkg::MODE_LO +: 2]};
			end

			// Input select storage, unused bits held at ones.
			always_ff @(posedge i_sys_clk or negedge rst_sync_q)
			begin
				if (!rst_sync_q)
					sel_q[g] <= dcc_pkg::RST_INPUT_SELECT;
				else if (wr_hit(A_SEL))
					sel_q[g] <= {dcc_pkg::MUX_UNUSED_READ, i_reg_wdata[dcc_pkg::NEG_SEL_LO +: 2],
						dcc_pkg::MUX_UNUSED_READ, i_reg_wdata[dcc_pkg::POS_SEL_LO +: 2]};
			end

			dcc_channel u_chan
			(
				.i_sys_clk(i_sys_clk),
				.i_rst_n(rst_sync_q),
				.i_cmp_raw((g == 0) ? i_cmp0_raw : i_cmp1_raw),
				.i_clr_rise(clr_bit(A_CTL, dcc_pkg::BIT_RISE)),
				.i_clr_fall(clr_bit(A_CTL, dcc_pkg::BIT_FALL)),
				.o_state(state[g]),
				.o_rise_flag(rise[g]),
				.o_fall_flag(fall[g])
			);

			// Request while an enabled flag is set.
			assign irq[g] = (rise[g] & mode_q[g][dcc_pkg::BIT_RISE]) | (fall[g] & mode_q[g][dcc_pkg::BIT_FALL]);
		end
	endgenerate

	// Read mux with live state and flags.
	always_comb
	begin
		rdata_d = 8'h00;
		unique case (i_reg_addr)
			dcc_pkg::ADDR_CMP0_CONTROL:
				rdata_d = {ctl_q[0][dcc_pkg::BIT_ON], state[0], rise[0], fall[0], ctl_q[0][dcc_pkg::NEG_HYS_LO +: 4]};
			dcc_pkg::ADDR_CMP1_CONTROL:
				rdata_d = {ctl_q[1][dcc_pkg::BIT_ON], state[1], rise[1], fall[1], ctl_q[1][dcc_pkg::NEG_HYS_LO +: 4]};
			dcc_pkg::ADDR_CMP0_MODE: rdata_d = mode_q[0];
			dcc_pkg::ADDR_CMP1_MODE: rdata_d = mode_q[1];
			dcc_pkg::ADDR_CMP0_INPUT_SELECT: rdata_d = sel_q[0];
			dcc_pkg::ADDR_CMP1_INPUT_SELECT: rdata_d = sel_q[1];
			default: rdata_d = 8'h00;
		endcase
	end

	assign o_reg_rdata = rdata_d;
	assign o_cmp0_on = ctl_q[0][dcc_pkg::BIT_ON];
	assign o_cmp1_on = ctl_q[1][dcc_pkg::BIT_ON];
	assign o_cmp0_pos_hysteresis = ctl_q[0][dcc_pkg::POS_HYS_LO +: 2];
	assign o_cmp1_pos_hysteresis = ctl_q[1][dcc_pkg::POS_HYS_LO +: 2];
	assign o_cmp0_neg_hysteresis = ctl_q[0][dcc_pkg::NEG_HYS_LO +: 2];
	assign o_cmp1_neg_hysteresis = ctl_q[1][dcc_pkg::NEG_HYS_LO +: 2];
	assign o_cmp0_neg_input_select = sel_q[0][dcc_pkg::NEG_SEL_LO +: 2];
	assign o_cmp1_neg_input_select = sel_q[1][dcc_pkg::NEG_SEL_LO +: 2];
	assign o_cmp0_pos_input_select = sel_q[0][dcc_pkg::POS_SEL_LO +: 2];
	assign o_cmp1_pos_input_select = sel_q[1][dcc_pkg::POS_SEL_LO +: 2];
	assign o_cmp0_response_mode = mode_q[0][dcc_pkg::MODE_LO +: 2];
	assign o_cmp1_response_mode = mode_q[1][dcc_pkg::MODE_LO +: 2];
	assign o_cmp0_irq = irq[0];
	assign o_cmp1_irq = irq[1];
endmodule : dcc_top

// ### test/dcc_top_chk.sv
// Checker for dcc_top: register port, unused bits and edge flag relations.
// Assumes it is bound to dcc_top and sees only its ports.
`timescale 1ns/1ps
module dcc_chk
(
	// Clock, reset and register port.
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	// Comparator signals.
	input wire logic i_cmp1_raw,
	input wire logic o_cmp1_on,
	input wire logic [1:0] o_cmp1_pos_hysteresis,
	input wire logic [1:0] o_cmp1_response_mode,
	input wire logic [1:0] o_cmp0_response_mode,
	input wire logic o_cmp1_irq
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);
	property p_ctl;
		i_reg_wr && i_reg_addr == 8'h9a |=> o_cmp1_on == $past(i_reg_wdata[7]) &&
			o_cmp1_pos_hysteresis == $past(i_reg_wdata[3:2]);
	endproperty
	a_ctl: assert property (p_ctl) else $error("control write not applied");
	property p_md1;
		i_reg_wr && i_reg_addr == 8'h9c |=> o_cmp1_response_mode == $past(i_reg_wdata[1:0]);
	endproperty
	a_md1: assert property (p_md1) else $error("mode1 write not applied");
	property p_md0;
		i_reg_wr && i_reg_addr == 8'h9d |=> o_cmp0_response_mode == $past(i_reg_wdata[1:0]);
	endproperty
	a_md0: assert property (p_md0) else $error("mode0 write not applied");
	property p_mux;
		i_reg_addr == 8'h9e |-> o_reg_rdata[7:6] == 2'h3 && o_reg_rdata[3:2] == 2'h3;
	endproperty
	a_mux: assert property (p_mux) else $error("select unused bits wrong");
	property p_mode;
		i_reg_addr inside {8'h9c, 8'h9d} |-> (o_reg_rdata & 8'hcc) == 8'h00;
	endproperty
	a_mode: assert property (p_mode) else $error("mode unused bits wrong");
	property p_state;
		i_cmp1_raw [*5] ##1 i_reg_addr == 8'h9a |-> o_reg_rdata[6];
	endproperty
	a_state: assert property (p_state) else $error("state bit not following");
	property p_rise;
		i_reg_addr == 8'h9a ##1 i_reg_addr == 8'h9a && $rose(o_reg_rdata[6]) |-> o_reg_rdata[5];
	endproperty
	a_rise: assert property (p_rise) else $error("rise flag not set");
	property p_irq;
		i_reg_addr == 8'h9a && o_reg_rdata[5:4] == 2'h0 |-> !o_cmp1_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq without flag");
	c_irq: cover property (o_cmp1_irq);
	c_rise: cover property (i_reg_addr == 8'h9a && o_reg_rdata[5]);
	c_fall: cover property (i_reg_addr == 8'h9a && o_reg_rdata[4]);
endmodule : dcc_chk
bind dcc_top dcc_chk u_chk (.i_sys_clk, .i_rstn, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .o_reg_rdata, .i_cmp1_raw,
	.o_cmp1_on, .o_cmp1_pos_hysteresis, .o_cmp1_response_mode, .o_cmp0_response_mode, .o_cmp1_irq);

// ### test/dcc_top_tb.sv
// Testbench for dcc_top: register table, unused bits, modes and edge flags.
// Assumes dcc_top and its bound checker are compiled before it.
`timescale 1ns/1ps
module dcc_top_tb;
	logic i_sys_clk, i_rstn, i_reg_wr, i_cmp0_raw, i_cmp1_raw, o_cmp0_on, o_cmp1_on, o_cmp0_irq, o_cmp1_irq;
	logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
	logic [1:0] o_cmp0_pos_hysteresis, o_cmp0_neg_hysteresis, o_cmp0_neg_input_select, o_cmp0_pos_input_select;
	logic [1:0] o_cmp1_pos_hysteresis, o_cmp1_neg_hysteresis, o_cmp1_neg_input_select, o_cmp1_pos_input_select;
	logic [1:0] o_cmp0_response_mode, o_cmp1_response_mode;
	logic [7:0] rows [6][3] = '{'{8'h9c, 8'hff, 8'h33}, '{8'h9d, 8'hce, 8'h02}, '{8'h9e, 8'h00, 8'hcc},
		'{8'h9a, 8'h8f, 8'h8f}, '{8'h9a, 8'h71, 8'h01}, '{8'ha0, 8'hff, 8'h00}};
	int errors, checks, cyc;
	logic [7:0] c, md;
	dcc_top uut (.i_sys_clk, .i_rstn, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .o_reg_rdata, .i_cmp0_raw, .i_cmp1_raw,
		.o_cmp0_on, .o_cmp0_pos_hysteresis, .o_cmp0_neg_hysteresis, .o_cmp0_neg_input_select,
		.o_cmp0_pos_input_select, .o_cmp0_response_mode, .o_cmp1_on, .o_cmp1_pos_hysteresis,
		.o_cmp1_neg_hysteresis, .o_cmp1_neg_input_select, .o_cmp1_pos_input_select, .o_cmp1_response_mode,
		.o_cmp0_irq, .o_cmp1_irq);
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		#1 i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		@(posedge i_sys_clk);
		#1 i_reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_sys_clk);
		#1 i_reg_addr = a;
		#4 chk("rdata", exp, o_reg_rdata);
	endtask : rd
	initial
	begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			errors++;
			report_and_stop();
		end
	end
	initial
	begin
		{i_rstn, i_reg_wr, i_cmp0_raw, i_cmp1_raw, i_reg_addr, i_reg_wdata} = '0;
		repeat (16) @(posedge i_sys_clk);
		#1 i_rstn = 1'b1;
		repeat (3) @(posedge i_sys_clk);
		foreach (rows[i])
		begin
			wr(rows[i][0], rows[i][1]);
			rd(rows[i][0], rows[i][2]);
		end
		wr(8'h9a, 8'h86);
		chk("cmp1 ctl out", 8'h86, {o_cmp1_on, 3'h0, o_cmp1_pos_hysteresis, o_cmp1_neg_hysteresis});
		wr(8'h9e, 8'h1b);
		chk("cmp1 sel out", 8'h13, {2'h0, o_cmp1_neg_input_select, 2'h0, o_cmp1_pos_input_select});
		wr(8'h9b, 8'h89);
		chk("cmp0 ctl out", 8'h89, {o_cmp0_on, 3'h0, o_cmp0_pos_hysteresis, o_cmp0_neg_hysteresis});
		wr(8'h9f, 8'h2e);
		chk("cmp0 sel out", 8'h22, {2'h0, o_cmp0_neg_input_select, 2'h0, o_cmp0_pos_input_select});
		rd(8'h9f, 8'hee);
		for (int m = 0; m < 4; m++)
		begin
			wr(8'h9c, 8'(m));
			wr(8'h9d, 8'(3 - m));
			chk("mode1", 8'(m), {6'h0, o_cmp1_response_mode});
			chk("mode0", 8'(3 - m), {6'h0, o_cmp0_response_mode});
		end
		$display("table and modes done");
		for (int n = 0; n < 2; n++)
		begin
			c = n ? 8'h9a : 8'h9b;
			md = n ? 8'h9c : 8'h9d;
			wr(c, 8'h00);
			wr(md, 8'h10);
			rd(c, 8'h00);
			@(posedge i_sys_clk);
			#1 {i_cmp1_raw, i_cmp0_raw} = 2'(n + 1);
			repeat (4) @(posedge i_sys_clk);
			rd(c, 8'h60);
			chk("irq", 8'h0, {7'h0, n ? o_cmp1_irq : o_cmp0_irq});
			@(posedge i_sys_clk);
			#1 {i_cmp1_raw, i_cmp0_raw} = 2'h0;
			repeat (4) @(posedge i_sys_clk);
			rd(c, 8'h30);
			chk("irq", 8'h1, {7'h0, n ? o_cmp1_irq : o_cmp0_irq});
			wr(c, 8'h20);
			rd(c, 8'h20);
			chk("irq", 8'h0, {7'h0, n ? o_cmp1_irq : o_cmp0_irq});
			wr(md, 8'h20);
			chk("irq", 8'h1, {7'h0, n ? o_cmp1_irq : o_cmp0_irq});
			wr(c, 8'h00);
			rd(c, 8'h00);
		end
		$display("edge flags done");
		wr(8'h9a, 8'h8f);
		@(posedge i_sys_clk);
		#1 i_rstn = 1'b0;
		repeat (2) @(posedge i_sys_clk);
		#1 i_rstn = 1'b1;
		repeat (3) @(posedge i_sys_clk);
		rd(8'h9a, 8'h00);
		rd(8'h9b, 8'h00);
		rd(8'h9c, 8'h02);
		rd(8'h9d, 8'h02);
		rd(8'h9e, 8'hff);
		rd(8'h9f, 8'hff);
		$display("reset values done");
		report_and_stop();
	end
endmodule : dcc_top_tb
